/* File: logic/spi_error_and_register_logic_params.svh */
// Offsets, field positions, reset values and rate counts of the serial port
// How it works
// - Master sees its select input low: declare a mode fault.
// - Mode fault clears master select and port D direction bits 2..5, requests interrupt.
// - Data write during a transfer sets write collision; shifter and transfer untouched.
// - Write collision is detected in master and in slave mode.
// - Master transfer runs from data write until the complete flag sets.
// - Slave phase 0: busy while select is low, even after completion.
// - Slave phase 0: complete flag and buffer load at eighth sampling edge.
// - Slave phase 1: busy from first active clock edge until complete flag.
// - Interrupt request on complete or fault, gated by enable and processor mask.
// - System enable hands port D bits 2..5 to the serial port.
// - Master with direction bit 5 set: select pin is a general output.
// - Open drain select turns every port D output into open drain.
// - Master select bit: 0 slave, 1 master.
// - Idle master holds serial clock at the polarity level.
// - Rate select divides the clock by 2, 4, 16, 32 in master only.
// - Complete flag set per byte; cleared by status read then data access.
// - Data writes ignored while complete flag set until status was read.
// - Write collision cleared by status read then data access.
// - Mode fault cleared by status read then control write.
// - Status bit 5 and bits 3..0 read zero.
// - Only a master data write starts a byte; both ends flag completion.
// - Data reads return the receive buffer; overrun keeps the older byte.
// - Phase 0 slave writing data while select low gets a collision.
// - Direction bit 5 set disables mode fault detection.
`ifndef SPI_ERROR_AND_REGISTER_LOGIC_PARAMS_SVH
`define SPI_ERROR_AND_REGISTER_LOGIC_PARAMS_SVH
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_DATA 8'h08
`define ADDR_DIRECTION 8'h0C
`define CONTROL_RESET 8'h00
`define DIRECTION_RESET 4'h0
`define PORT_INTERRUPT_ENABLE 7
`define PORT_SYSTEM_ENABLE 6
`define OPEN_DRAIN_SELECT 5
`define MASTER_SELECT 4
`define CLOCK_POLARITY 3
`define CLOCK_PHASE 2
`define TRANSFER_COMPLETE_FLAG 7
`define WRITE_COLLISION_FLAG 6
`define MODE_FAULT_FLAG 4
`define GP_LEVEL_BIT 0
`define HALF_DIV2 5'h01
`define HALF_DIV4 5'h02
`define HALF_DIV16 5'h08
`define HALF_DIV32 5'h10
`define LAST_EDGE 5'h0F
`endif

/* File: logic/spi_error_and_register_logic_pkg.sv */
// Types shared by the serial port logic
package spi_error_and_register_logic_pkg;
  typedef enum logic {m_idle, m_run} master_state_t;
  typedef logic [7:0] byte_t;
endpackage

/* File: logic/spi_error_and_register_logic.sv */
// Serial port registers, shift engine and error detection behind an APB slave
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "spi_error_and_register_logic_params.svh"
module spi_error_and_register_logic (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_mask_bit,
  output logic irq_request,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic ss_n_oe
);
  import spi_error_and_register_logic_pkg::*;

  // ==========================================================
  // Pin input filtering
  logic [3:0] pin_raw;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] pin_f;
  assign pin_raw = {ss_n_in, sck_in, mosi_in, miso_in};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // Level only moves once two late stages agree, so one glitch never counts
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
          sync3[gi] <= 1'b1;
          pin_f[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_f[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate
  logic miso_f, mosi_f, sck_f, ss_n_f, sck_prev;

  assign miso_f = pin_f[0];
  assign mosi_f = pin_f[1];
  assign sck_f = pin_f[2];
  assign ss_n_f = pin_f[3];

  // ==========================================================
  // Register state and decode
  byte_t ctl;
  logic [5:2] port_d_direction;
  logic gp_level;
  byte_t shifter, rx_buffer;
  logic tcf, write_collision_flag, mode_fault_flag;
  logic arm_tcf, arm_write_collision_flag, arm_mode_fault_flag;
  logic port_interrupt_enable, port_system_enable, open_drain_select;
  logic master_select, clock_polarity, clock_phase;
  logic [1:0] rate_select;
  assign port_interrupt_enable = ctl[`PORT_INTERRUPT_ENABLE];
  assign port_system_enable = ctl[`PORT_SYSTEM_ENABLE];
  assign open_drain_select = ctl[`OPEN_DRAIN_SELECT];
  assign master_select = ctl[`MASTER_SELECT];
  assign clock_polarity = ctl[`CLOCK_POLARITY];
  assign clock_phase = ctl[`CLOCK_PHASE];
  assign rate_select = ctl[1:0];

  logic acc, wr, rd, ctl_wr, dir_wr, stat_rd, data_wr, data_rd, data_acc;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign ctl_wr = wr & (paddr == `ADDR_CONTROL);
  assign dir_wr = wr & (paddr == `ADDR_DIRECTION);
  assign stat_rd = rd & (paddr == `ADDR_STATUS);
  assign data_wr = wr & (paddr == `ADDR_DATA);
  assign data_rd = rd & (paddr == `ADDR_DATA);
  assign data_acc = data_wr | data_rd;

  // ==========================================================
  // Mode, fault and busy terms
  logic is_master, is_slave, mode_fault, busy, slave_act, load;
  master_state_t mstate;
  assign is_master = port_system_enable & master_select;
  assign is_slave = port_system_enable & ~master_select;
  // fault detect, inhibited by direction bit 5
  assign mode_fault = is_master & ~port_d_direction[5] & ~ss_n_f;
  assign busy = (mstate == m_run) |
                (is_slave & (clock_phase ? slave_act : ~ss_n_f));
  // blocked until status read; collision never loads
  assign load = data_wr & ~busy & (~tcf | arm_tcf);

  // ==========================================================
  // APB slave, zero wait, error on unmapped offsets
  logic mapped;
  assign mapped = (paddr == `ADDR_CONTROL) | (paddr == `ADDR_STATUS) |
                  (paddr == `ADDR_DATA) | (paddr == `ADDR_DIRECTION);
  // Read data formed in setup so it is a flop at the access edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel & ~penable) begin
        pslverr <= ~mapped;
        unique case (paddr)
          `ADDR_CONTROL: prdata <= {24'h00_0000, ctl};
          `ADDR_STATUS: prdata <= {24'h00_0000, tcf, write_collision_flag, 1'b0, mode_fault_flag, 4'h0};
          `ADDR_DATA: prdata <= {24'h00_0000, rx_buffer};
          `ADDR_DIRECTION: prdata <= {24'h00_0000, 2'b00, port_d_direction, 1'b0, gp_level};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; a fault overrides a write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctl <= `CONTROL_RESET;
    end else if (mode_fault) begin
      ctl[`MASTER_SELECT] <= 1'b0;
    end else if (ctl_wr) begin
      ctl <= pwdata[7:0];
    end
  end

  // Port D direction bits of the serial pins plus select pin level
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_d_direction <= `DIRECTION_RESET;
      gp_level <= 1'b0;
    end else if (mode_fault) begin
      port_d_direction <= 4'h0;
    end else if (dir_wr) begin
      port_d_direction <= pwdata[5:2];
      gp_level <= pwdata[`GP_LEVEL_BIT];
    end
  end

  // ==========================================================
  // Master clock generator
  logic [4:0] half, div_cnt, edge_cnt;
  logic sck_lvl, m_edge;
  always_comb begin
    unique case (rate_select)
      2'b00: half = `HALF_DIV2;
      2'b01: half = `HALF_DIV4;
      2'b10: half = `HALF_DIV16;
      2'b11: half = `HALF_DIV32;
    endcase
  end
  assign m_edge = (mstate == m_run) & (div_cnt == half - 5'h01);

  // a master data write starts the byte
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mstate <= m_idle;
      div_cnt <= 5'h00;
      edge_cnt <= 5'h00;
      sck_lvl <= 1'b0;
    end else begin
      unique case (mstate)
        m_idle: begin
          sck_lvl <= clock_polarity;
          div_cnt <= 5'h00;
          edge_cnt <= 5'h00;
          if (load & is_master) begin
            mstate <= m_run;
          end
        end
        m_run: begin
          if (!is_master) begin
            mstate <= m_idle;
          end else if (m_edge) begin
            div_cnt <= 5'h00;
            sck_lvl <= ~sck_lvl;
            edge_cnt <= edge_cnt + 5'h01;
            if (edge_cnt == `LAST_EDGE) begin
              mstate <= m_idle;
            end
          end else begin
            div_cnt <= div_cnt + 5'h01;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Shift engine shared by both modes
  logic s_lead, s_trail, lead, trail, samp_ev, shift_ev, samp_bit, byte_done;
  logic rx_bit;
  logic [2:0] bit_cnt;
  logic sel_ok;
  assign sel_ok = is_slave & ~ss_n_f;
  assign s_lead = sel_ok & (sck_f != sck_prev) & (sck_f != clock_polarity);
  assign s_trail = sel_ok & (sck_f != sck_prev) & (sck_f == clock_polarity);
  assign lead = is_master ? (m_edge & ~edge_cnt[0]) : s_lead;
  assign trail = is_master ? (m_edge & edge_cnt[0]) : s_trail;
  assign samp_bit = is_master ? miso_f : mosi_f;
  // phase 0 samples on leading edges, phase 1 on trailing
  assign samp_ev = clock_phase ? trail : lead;
  assign shift_ev = clock_phase ? (lead & (bit_cnt != 3'h0)) : trail;
  assign byte_done = samp_ev & (bit_cnt == 3'h7);

  // eight bits, msb first, both lines together
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      shifter <= 8'h00;
      rx_bit <= 1'b0;
      bit_cnt <= 3'h0;
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= sck_f;
      if (load) begin
        shifter <= pwdata[7:0];
        bit_cnt <= 3'h0;
      end else if (is_slave & ss_n_f & ~clock_phase) begin
        bit_cnt <= 3'h0;
      end else begin
        if (samp_ev) begin
          rx_bit <= samp_bit;
          bit_cnt <= bit_cnt + 3'h1;
        end
        if (shift_ev) begin
          shifter <= {shifter[6:0], rx_bit};
        end
      end
    end
  end

  // phase 1 slave active from first edge to completion
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      slave_act <= 1'b0;
    end else if (!is_slave | byte_done) begin
      slave_act <= 1'b0;
    end else if (s_lead & (bit_cnt == 3'h0)) begin
      slave_act <= 1'b1;
    end
  end

  // overrun keeps the unread byte; new one is lost
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_buffer <= 8'h00;
    end else if (byte_done & ~tcf) begin
      rx_buffer <= {shifter[6:0], samp_bit};
    end
  end

  // ==========================================================
  // Status flags; a set always beats a clear in the same cycle
  logic tcf_set;
  // master completes at last edge, slave at last sample
  assign tcf_set = is_master ? (m_edge & (edge_cnt == `LAST_EDGE)) : (is_slave & byte_done);
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tcf <= 1'b0;
      arm_tcf <= 1'b0;
    end else if (tcf_set) begin
      tcf <= 1'b1;
      arm_tcf <= 1'b0;
    end else if (data_acc & arm_tcf) begin
      tcf <= 1'b0;
      arm_tcf <= 1'b0;
    end else if (stat_rd & tcf) begin
      arm_tcf <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      write_collision_flag <= 1'b0;
      arm_write_collision_flag <= 1'b0;
    end else if (data_wr & busy) begin
      write_collision_flag <= 1'b1;
      arm_write_collision_flag <= 1'b0;
    end else if (data_acc & arm_write_collision_flag) begin
      write_collision_flag <= 1'b0;
      arm_write_collision_flag <= 1'b0;
    end else if (stat_rd & write_collision_flag) begin
      arm_write_collision_flag <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_fault_flag <= 1'b0;
      arm_mode_fault_flag <= 1'b0;
    end else if (mode_fault) begin
      mode_fault_flag <= 1'b1;
      arm_mode_fault_flag <= 1'b0;
    end else if (ctl_wr & arm_mode_fault_flag) begin
      mode_fault_flag <= 1'b0;
      arm_mode_fault_flag <= 1'b0;
    end else if (stat_rd & mode_fault_flag) begin
      arm_mode_fault_flag <= 1'b1;
    end
  end

  // enable and processor mask gate the request
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= port_interrupt_enable & ~irq_mask_bit & (tcf | mode_fault_flag);
    end
  end

  // ==========================================================
  // Pin drivers; open drain only ever drives low
  logic m_sck;
  assign m_sck = (mstate == m_run) ? sck_lvl : clock_polarity;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      ss_n_out <= 1'b0;
      ss_n_oe <= 1'b0;
    end else begin
      sck_out <= m_sck;
      mosi_out <= shifter[7];
      miso_out <= shifter[7];
      ss_n_out <= gp_level;
      // enabled pins, open drain releases ones
      sck_oe <= is_master & port_d_direction[4] & (~open_drain_select | ~m_sck);
      mosi_oe <= is_master & port_d_direction[3] & (~open_drain_select | ~shifter[7]);
      miso_oe <= sel_ok & port_d_direction[2] & (~open_drain_select | ~shifter[7]);
      ss_n_oe <= is_master & port_d_direction[5] & (~open_drain_select | ~gp_level);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_fault_drops_master: assert property (mode_fault |=> !master_select && port_d_direction == 4'h0)
    else $error("mode fault left master or drivers on");
  chk_collision_flagged: assert property (data_wr && busy |=> write_collision_flag)
    else $error("write during transfer not flagged");
  chk_collision_no_restart: assert property (data_wr && mstate == m_run && is_master |=> mstate == m_run)
    else $error("collision disturbed master transfer");
  chk_idle_clock_level: assert property (mstate == m_idle |=> sck_out == $past(clock_polarity))
    else $error("idle serial clock not at polarity");
  chk_fast_rate_time: assert property (load && is_master && rate_select == 2'b00 && !ctl_wr |-> ##[17:18] tcf)
    else $error("divide by two byte not done in time");
  chk_blocked_write: assert property (data_wr && tcf && !arm_tcf && mstate == m_idle |=> mstate == m_idle)
    else $error("data write not ignored while flag pending");
  chk_irq_off: assert property (!port_interrupt_enable || irq_mask_bit |=> !irq_request)
    else $error("interrupt not masked");
  chk_status_zero: assert property ($past(psel && !penable && paddr == `ADDR_STATUS) |-> prdata[5] == 1'b0 && prdata[3:0] == 4'h0)
    else $error("unused status bits not zero");
  chk_fault_clear: assert property (ctl_wr && arm_mode_fault_flag && !mode_fault |=> !mode_fault_flag)
    else $error("mode fault not cleared");
  chk_tcf_clear: assert property (data_acc && arm_tcf && !tcf_set |=> !tcf)
    else $error("complete flag not cleared");
  cov_master_byte: cover property (is_master && tcf_set);
  cov_slave_byte: cover property (is_slave && byte_done);
  cov_collision: cover property (data_wr && busy);
  cov_fault: cover property (mode_fault);
endmodule // spi_error_and_register_logic

/* File: verification/far_end_model.sv */
// Far side of the serial link: a phase 0 slave, plus a select line driver
`timescale 1ns/10ps
module far_end_model (
  input wire logic core_clk,
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n_req,
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic ss_n,
  output logic [7:0] rx_byte,
  output logic [7:0] half_cycles
);
  logic [7:0] shifter;
  logic [7:0] count;
  logic sck_q;
  // ==========================================================
  // Select line
  // Driving select low while the block is master with direction bit 5 clear provokes a fault
  // far end select drive
  assign ss_n = sel_n_req;
  // ==========================================================
  // Shifting, eight bits each way
  // msb first both lines
  assign miso = shifter[7];
  always @(posedge sck) begin
    rx_byte <= {rx_byte[6:0], mosi};
  end
  // Refill with inverted bits so a stale miso never looks valid
  always @(negedge sck or posedge load) begin
    if (load) begin
      shifter <= tx_byte;
    end else begin
      shifter <= {shifter[6:0], ~shifter[0]};
    end
  end
  // ==========================================================
  // Serial clock half period, in core cycles
  always @(posedge core_clk) begin
    sck_q <= sck;
    if (sck !== sck_q) begin
      half_cycles <= count;
      count <= 8'h01;
    end else begin
      count <= count + 8'h01;
    end
  end
  initial begin
    count = 8'h00;
    rx_byte = 8'h00;
  end
endmodule // far_end_model

/* File: verification/testbench.sv */
// Self-checking bench for the serial port register and error logic
`timescale 1ns/10ps
`include "spi_error_and_register_logic_params.svh"
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  import spi_error_and_register_logic_pkg::*;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, irq_mask_bit = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_request, miso, ss_n, sck_out, mosi_out;
  logic sel_n_req = 1, load = 0;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] rx_byte, half_cycles;
  byte_t q;
  logic err;
  int mismatches = 0, n_compared = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  spi_error_and_register_logic i_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_mask_bit(irq_mask_bit),
    .irq_request(irq_request), .miso_in(miso), .miso_out(), .miso_oe(), .mosi_in(1'b0),
    .mosi_out(mosi_out), .mosi_oe(), .sck_in(1'b0), .sck_out(sck_out), .sck_oe(),
    .ss_n_in(ss_n), .ss_n_out(), .ss_n_oe());
  far_end_model i_far (.core_clk(core_clk), .sck(sck_out), .mosi(mosi_out),
    .sel_n_req(sel_n_req), .load(load), .tx_byte(tx_byte), .miso(miso), .ss_n(ss_n),
    .rx_byte(rx_byte), .half_cycles(half_cycles));
  // ==========================================================
  // APB master: setup, access until pready, release
  task automatic apb(input logic wr, input logic [7:0] a, input byte_t d);
    int n;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers counts against the run
    if (pready !== 1'b1) begin
      mismatches++;
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic preload(input byte_t b);
    @(posedge core_clk);
    tx_byte <= b;
    load <= 1;
    @(posedge core_clk);
    load <= 0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_reset_map();
    apb(0, `ADDR_CONTROL, 8'h00); `CHECK("control", 8'h00, q)
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("status", 8'h00, q)
    apb(0, 8'h10, 8'h00); `CHECK("unmapped err", 1'b1, err)
    $display("test reset_map done");
  endtask
  task automatic test_master_byte();
    int n;
    preload(8'h3C);
    apb(1, `ADDR_DIRECTION, 8'h1C);
    apb(1, `ADDR_CONTROL, 8'hD2);
    idle(3); `CHECK("idle sck", 1'b0, sck_out)
    apb(1, `ADDR_DATA, 8'hA5);
    apb(1, `ADDR_DATA, 8'h5A);
    n = 0;
    do begin
      apb(0, `ADDR_STATUS, 8'h00);
      n++;
    end while (q[7] !== 1'b1 && n < 200);
    `CHECK("status tcf write_collision_flag", 8'hC0, q)
    `CHECK("masked irq", 1'b0, irq_request)
    `CHECK("half period", 8'h08, half_cycles)
    `CHECK("far end got", 8'hA5, rx_byte)
    irq_mask_bit <= 0;
    idle(3); `CHECK("irq", 1'b1, irq_request)
    apb(0, `ADDR_DATA, 8'h00); `CHECK("rx buffer", 8'h3C, q)
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("status cleared", 8'h00, q)
    idle(3); `CHECK("irq off", 1'b0, irq_request)
    $display("test master_byte done");
  endtask
  task automatic test_write_inhibit();
    int n;
    preload(8'hC3);
    apb(1, `ADDR_DATA, 8'h81);
    n = 0;
    while (irq_request !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    `CHECK("complete", 1'b1, irq_request)
    apb(1, `ADDR_DATA, 8'h11);
    idle(200); `CHECK("no new byte", 8'h81, rx_byte)
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("no collision", 8'h80, q)
    apb(0, `ADDR_DATA, 8'h00); `CHECK("rx buffer", 8'hC3, q)
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("cleared", 8'h00, q)
    $display("test write_inhibit done");
  endtask
  task automatic test_mode_fault();
    apb(1, `ADDR_CONTROL, 8'h58);
    idle(3); `CHECK("idle sck high", 1'b1, sck_out)
    sel_n_req <= 0;
    idle(8);
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("fault", 8'h10, q)
    apb(0, `ADDR_CONTROL, 8'h00); `CHECK("master off", 8'h48, q)
    apb(0, `ADDR_DIRECTION, 8'h00); `CHECK("drivers off", 8'h00, q)
    sel_n_req <= 1;
    // Let the pin filter see select high before master mode returns
    idle(6);
    apb(1, `ADDR_CONTROL, 8'h50);
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("fault cleared", 8'h00, q)
    apb(1, `ADDR_DIRECTION, 8'h3C);
    sel_n_req <= 0;
    idle(8);
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("fault off", 8'h00, q)
    apb(0, `ADDR_CONTROL, 8'h00); `CHECK("still master", 8'h50, q)
    // Fastest rate byte, done in seventeen to eighteen of the twenty cycles
    apb(1, `ADDR_DATA, 8'h96);
    idle(20);
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("fast byte", 8'h80, q)
    `CHECK("fast far end", 8'h96, rx_byte)
    apb(0, `ADDR_DATA, 8'h00);
    sel_n_req <= 1;
    idle(6);
    $display("test mode_fault done");
  endtask
  task automatic test_slave_collision();
    apb(1, `ADDR_CONTROL, 8'h40);
    sel_n_req <= 0;
    idle(8);
    apb(1, `ADDR_DATA, 8'h77);
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("slave write_collision_flag", 8'h40, q)
    sel_n_req <= 1;
    apb(0, `ADDR_DATA, 8'h00);
    apb(0, `ADDR_STATUS, 8'h00); `CHECK("write_collision_flag cleared", 8'h00, q)
    $display("test slave_collision done");
  endtask
  // ==========================================================
  // Verdict and hang guard
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1;
    idle(5);
    test_reset_map();
    test_master_byte();
    test_write_inhibit();
    test_mode_fault();
    test_slave_collision();
    complete_run();
  end
endmodule // testbench
